// ### rsc_pkg.sv
// Constants shared by the reset source combiner and its helper modules.
// Assumes a single 100 MHz clock and a 32-bit classic Wishbone register port.
package rsc_pkg;
   localparam int CAUSE_W = 16;
   localparam int SRC_W = 8;
   // Flag positions in the cause register
   localparam int BIT_TRAP = 15;
   localparam int BIT_IOP = 14;
   localparam int BIT_CM = 9;
   localparam int BIT_VREG = 8;
   localparam int BIT_EXT = 7;
   localparam int BIT_SWR = 6;
   localparam int BIT_SWDT = 5;
   localparam int BIT_WATCHDOG_TIMEOUT_FLAG = 4;
   localparam int BIT_SLEEP = 3;
   localparam int BIT_IDLE = 2;
   localparam int BIT_BOR = 1;
   localparam int BIT_POR = 0;
   localparam logic [15:0] CAUSE_RST = 16'h0003;
   localparam logic [15:0] CAUSE_IMPL = 16'hc3ff;
   // Live source register bit positions
   localparam int SRC_BOR = 0;
   localparam int SRC_EXT = 1;
   localparam int SRC_SWR = 2;
   localparam int SRC_WDT = 3;
   localparam int SRC_TRAP = 4;
   localparam int SRC_IOP = 5;
   localparam int SRC_UWR = 6;
   localparam int SRC_CM = 7;
   // Wishbone byte addresses
   localparam int ADR_W = 4;
   localparam logic [3:0] ADR_CAUSE = 4'h0;
   localparam logic [3:0] ADR_SRC = 4'h4;
   // Clock cycles the master reset is held after the last source drops
   localparam int REL_STAGES = 2;
endpackage : rsc_pkg

// ### rsc_cause_if.sv
// Carrier between the combiner top and its cause register.
// Assumes the package rsc_pkg is compiled first.
`timescale 1ns/1ns
`default_nettype none
interface rsc_cause_if;
   logic [rsc_pkg::CAUSE_W-1:0] setVec;
   logic [rsc_pkg::CAUSE_W-1:0] clrVec;
   logic wrEn;
   logic [rsc_pkg::CAUSE_W-1:0] wrMask;
   logic [rsc_pkg::CAUSE_W-1:0] wrData;
   logic [rsc_pkg::CAUSE_W-1:0] value;
   modport owner (input setVec, clrVec, wrEn, wrMask, wrData, output value);
   modport user (output setVec, clrVec, wrEn, wrMask, wrData, input value);
endinterface : rsc_cause_if
`default_nettype wire

// ### rsc_cause_reg.sv
// Reset cause register: hardware set, hardware clear and software write.
// Assumes rst_b is the power-on reset; no other reset reaches this register.
`timescale 1ns/1ns
`default_nettype none
module rsc_cause_reg (
   input wire logic mclk,
   input wire logic rst_b,
   rsc_cause_if.owner cif
);
   logic [rsc_pkg::CAUSE_W-1:0] cause_r;
   logic [rsc_pkg::CAUSE_W-1:0] cause_nxt;

   always_comb begin
      cause_nxt = cause_r;
      if (cif.wrEn) begin
         // Plain storage only, nothing here feeds the reset path
         cause_nxt = (cause_r & ~cif.wrMask) | (cif.wrData & cif.wrMask);
      end
      cause_nxt = cause_nxt & ~cif.clrVec;
      // Hardware set applied last so it wins over any clear
      cause_nxt = (cause_nxt | cif.setVec) & rsc_pkg::CAUSE_IMPL;
   end

   // Only power-on resets this; other resets leave it intact
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cause_r <= rsc_pkg::CAUSE_RST;
      end else begin
         cause_r <= cause_nxt;
      end
   end

   assign cif.value = cause_r;
endmodule : rsc_cause_reg
`default_nettype wire

// ### rsc_release_sync.sv
// Holds a reset request and releases it a fixed number of clocks later.
// Assumes hold is synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module rsc_release_sync #(
   parameter int STAGES = rsc_pkg::REL_STAGES
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic hold,
   output logic holdOut
);
   logic [STAGES-1:0] stage_r;
   logic [STAGES-1:0] stage_nxt;

   always_comb begin
      if (hold) begin
         stage_nxt = '1;
      end else begin
         stage_nxt = {stage_r[STAGES-2:0], 1'b0};
      end
   end

   // Async assert on power-on, release only on a clock edge
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stage_r <= '1;
      end else begin
         stage_r <= stage_nxt;
      end
   end

   assign holdOut = stage_r[STAGES-1];
endmodule : rsc_release_sync
`default_nettype wire

// ### rsc_reset_source_combiner.sv
// Reset source combiner: master system reset and reset cause register.
// Assumes all source inputs are synchronous, active-high levels.
`timescale 1ns/1ns
`default_nettype none
module rsc_reset_source_combiner (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic brownoutReset,
   input wire logic externalPinReset,
   input wire logic instructionReset,
   input wire logic watchdogReset,
   input wire logic trapConflict,
   input wire logic illegalOpcode,
   input wire logic uninitWregReset,
   input wire logic configMismatch,
   input wire logic sleepEntry,
   input wire logic idleEntry,
   input wire logic pwrsavExec,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [rsc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic masterSystemReset,
   output logic watchdogSwEnable,
   output logic regulatorActiveSleep
);
   rsc_cause_if causeIf ();

   logic [rsc_pkg::SRC_W-1:0] srcVec;
   logic anySource;
   logic relHold;
   logic wbReq;
   logic ack_r;
   logic ack_nxt;
   logic [31:0] dat_r;
   logic [31:0] dat_nxt;
   logic [rsc_pkg::CAUSE_W-1:0] setVec;
   logic [rsc_pkg::CAUSE_W-1:0] clrVec;

   // Live view of the eight reset sources
   always_comb begin
      srcVec = '0;
      srcVec[rsc_pkg::SRC_BOR] = brownoutReset;
      srcVec[rsc_pkg::SRC_EXT] = externalPinReset;
      srcVec[rsc_pkg::SRC_SWR] = instructionReset;
      srcVec[rsc_pkg::SRC_WDT] = watchdogReset;
      srcVec[rsc_pkg::SRC_TRAP] = trapConflict;
      srcVec[rsc_pkg::SRC_IOP] = illegalOpcode;
      srcVec[rsc_pkg::SRC_UWR] = uninitWregReset;
      srcVec[rsc_pkg::SRC_CM] = configMismatch;
   end

   assign anySource = |srcVec;

   rsc_release_sync #(
      .STAGES(rsc_pkg::REL_STAGES)
   ) u_release (
      .mclk(mclk),
      .rst_b(rst_b),
      .hold(anySource),
      .holdOut(relHold)
   );

   // Assertion is immediate; release waits for the synchronous hold.
   // Peripherals and CPU take this as their reset
   assign masterSystemReset = anySource | relHold;

   // Cause flags raised by each source
   always_comb begin
      setVec = '0;
      setVec[rsc_pkg::BIT_TRAP] = trapConflict;
      setVec[rsc_pkg::BIT_IOP] = illegalOpcode | uninitWregReset;
      setVec[rsc_pkg::BIT_CM] = configMismatch;
      setVec[rsc_pkg::BIT_EXT] = externalPinReset;
      setVec[rsc_pkg::BIT_SWR] = instructionReset;
      setVec[rsc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = watchdogReset;
      setVec[rsc_pkg::BIT_SLEEP] = sleepEntry;
      setVec[rsc_pkg::BIT_IDLE] = idleEntry;
      setVec[rsc_pkg::BIT_BOR] = brownoutReset;
   end

   // Entering a power-save mode clears the watchdog time-out flag
   always_comb begin
      clrVec = '0;
      clrVec[rsc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = pwrsavExec;
   end

   assign causeIf.setVec = setVec;
   assign causeIf.clrVec = clrVec;

   // Classic Wishbone: one wait state, write lands on the acked edge
   assign wbReq = wb_cyc_i & wb_stb_i;
   assign ack_nxt = wbReq & ~ack_r;

   // Flags are plain storage for software
   assign causeIf.wrEn = wbReq & wb_we_i & ack_r & (wb_adr_i == rsc_pkg::ADR_CAUSE);
   assign causeIf.wrMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & rsc_pkg::CAUSE_IMPL;
   assign causeIf.wrData = wb_dat_i[rsc_pkg::CAUSE_W-1:0];

   rsc_cause_reg u_cause (
      .mclk(mclk),
      .rst_b(rst_b),
      .cif(causeIf)
   );

   // Read data captured when ack is raised and held with it.
   // Unmapped offsets still answer, reading zero, so a bus never hangs.
   always_comb begin
      dat_nxt = dat_r;
      if (ack_nxt) begin
         unique case (wb_adr_i)
            rsc_pkg::ADR_CAUSE: begin
               dat_nxt = {16'h0000, causeIf.value};
            end
            rsc_pkg::ADR_SRC: begin
               dat_nxt = {24'h000000, srcVec};
            end
            default: begin
               dat_nxt = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end else begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   // Control bits sharing the cause register steer neighbouring blocks
   assign watchdogSwEnable = causeIf.value[rsc_pkg::BIT_SWDT];
   assign regulatorActiveSleep = causeIf.value[rsc_pkg::BIT_VREG];
endmodule : rsc_reset_source_combiner
`default_nettype wire

// ### rsc_props.sv
// Assertions on the reset combiner ports.
// Assumes one clock; bound to the top module.
`timescale 1ns/1ns
`default_nettype none
module rsc_props (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic brownoutReset,
   input wire logic externalPinReset,
   input wire logic instructionReset,
   input wire logic watchdogReset,
   input wire logic trapConflict,
   input wire logic illegalOpcode,
   input wire logic uninitWregReset,
   input wire logic configMismatch,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [rsc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic masterSystemReset
);
   wire anySrc = brownoutReset | externalPinReset | instructionReset | watchdogReset
      | trapConflict | illegalOpcode | uninitWregReset | configMismatch;
   wire rdCause = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   AST_SRC_RST: assert property (anySrc |-> masterSystemReset)
      else $error("no reset with a source active");
   // If no source rises in the next cycle either, that cycle must stay quiet too
   AST_QUIET: assert property ((!anySrc && !masterSystemReset) ##1 !anySrc
      |-> !masterSystemReset)
      else $error("reset without a source");
   AST_RELEASE: assert property (!anySrc && $past(anySrc) |->
      masterSystemReset ##1 masterSystemReset ##1 !masterSystemReset)
      else $error("bad reset release");
   AST_POR_HOLD: assert property ($rose(rst_b) && !anySrc |->
      masterSystemReset[*2] ##1 !masterSystemReset)
      else $error("bad release after power-on");
   AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not one cycle");
   AST_MASK: assert property (rdCause |->
      wb_dat_o[31:16] == 16'h0 && wb_dat_o[13:10] == 4'h0)
      else $error("unimplemented bits read set");
   AST_WDT_FLAG: assert property (rdCause && $past(watchdogReset, 2) |->
      wb_dat_o[4])
      else $error("watchdog flag missing");
   AST_TRAP_FLAG: assert property (rdCause && $past(trapConflict, 2) |->
      wb_dat_o[15])
      else $error("trap flag missing");
   cover property (rdCause && wb_dat_o[15]);
   cover property ($fell(masterSystemReset));
   cover property (wb_ack_o && wb_we_i);
endmodule : rsc_props
bind rsc_reset_source_combiner rsc_props chk (.*);
`default_nettype wire

// ### rsc_src_model.sv
// Far side: monitors, pin, watchdog and core firing reset sources.
// Assumes commands arrive just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module rsc_src_model (
   input wire logic mclk,
   input wire logic [7:0] cmd,
   input wire logic [3:0] len,
   output logic [7:0] src
);
   logic [7:0] src_r = 8'h0;
   logic [3:0] cnt_r = 4'h0;
   assign src = src_r;
   // Len above one mimics a slow source that lingers
   always_ff @(posedge mclk) begin
      if (cmd != 8'h0) begin
         src_r <= cmd;
         cnt_r <= len;
      end else if (cnt_r > 4'h1) cnt_r <= cnt_r - 4'h1;
      else src_r <= 8'h0;
   end
endmodule : rsc_src_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the reset source combiner.
// Assumes package, design, model and checker compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin fails++; \
   $display("BAD %0t %h %h", $time, (a), (e)); end end
module tb;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] datI = 32'h0;
   logic [31:0] datO;
   logic [31:0] rd;
   logic ack;
   logic msr;
   logic [7:0] cmd = 8'h0;
   logic [3:0] len = 4'h1;
   logic [7:0] src;
   logic swEn;
   logic regAct;
   logic sleep = 1'b0;
   logic idle = 1'b0;
   logic pws = 1'b0;
   int fails = 0;
   int nCompared = 0;
   int bitPos [8] = '{1, 7, 6, 4, 15, 14, 14, 9};
   always #5 mclk = ~mclk;
   rsc_src_model model (.mclk(mclk), .cmd(cmd), .len(len), .src(src));
   rsc_reset_source_combiner dut (.mclk(mclk), .rst_b(rst_b),
      .brownoutReset(src[0]), .externalPinReset(src[1]), .instructionReset(src[2]),
      .watchdogReset(src[3]), .trapConflict(src[4]), .illegalOpcode(src[5]),
      .uninitWregReset(src[6]), .configMismatch(src[7]), .sleepEntry(sleep),
      .idleEntry(idle), .pwrsavExec(pws), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
      .wb_ack_o(ack), .masterSystemReset(msr), .watchdogSwEnable(swEn),
      .regulatorActiveSleep(regAct));
   task automatic report_and_stop;
      if (fails == 0 && nCompared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datI <= d;
      sel <= (a == 4'h0 && d[31]) ? 4'h1 : 4'h3;
      // Ack and data are read at the rising edge, before that edge updates them
      @(posedge mclk);
      while (ack !== 1'b1) @(posedge mclk);
      rd = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic fire(input int i, input logic [3:0] n);
      @(posedge mclk);
      cmd <= 8'h1 << i;
      len <= n;
      @(posedge mclk);
      cmd <= 8'h0;
      #1 `CHK(msr, 1'b1)
   endtask : fire
   initial begin
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      wb(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'h3)
      wb(1'b1, 4'h0, 32'h0000_ffff);
      wb(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'hc3ff)
      `CHK(msr, 1'b0)
      `CHK(swEn, 1'b1)
      `CHK(regAct, 1'b1)
      wb(1'b1, 4'h0, 32'h0);
      #1 `CHK(swEn, 1'b0)
      `CHK(regAct, 1'b0)
      // Top bit of data picks the low byte lane only
      wb(1'b1, 4'h0, 32'h8000_ffff);
      wb(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'hff)
      wb(1'b1, 4'h4, 32'hffff);
      wb(1'b0, 4'h4, 32'h0);
      `CHK(rd, 32'h0)
      wb(1'b0, 4'h8, 32'h0);
      `CHK(rd, 32'h0)
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, 4'h0, 32'h0);
         fire(i, i == 1 ? 4'h4 : 4'h1);
         wb(1'b0, 4'h0, 32'h0);
         `CHK(rd, 32'h1 << bitPos[i])
         repeat (8) if (msr) @(posedge mclk);
         #1 `CHK(msr, 1'b0)
      end
      // A brown-out reset keeps what software stored
      wb(1'b1, 4'h0, 32'h0000_ffff);
      fire(0, 4'h1);
      wb(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'hc3ff)
      repeat (8) if (msr) @(posedge mclk);
      wb(1'b1, 4'h0, 32'h0);
      // Watchdog and power-save clear in one cycle: the set wins
      @(posedge mclk);
      cmd <= 8'h08;
      @(posedge mclk);
      cmd <= 8'h00;
      pws <= 1'b1;
      sleep <= 1'b1;
      @(posedge mclk);
      pws <= 1'b0;
      sleep <= 1'b0;
      wb(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'h18)
      repeat (8) if (msr) @(posedge mclk);
      // Power-save alone clears the time-out flag; idle is no reset source
      @(posedge mclk);
      pws <= 1'b1;
      idle <= 1'b1;
      @(posedge mclk);
      pws <= 1'b0;
      idle <= 1'b0;
      wb(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'h0c)
      `CHK(msr, 1'b0)
      // Second power-on in mid-run over a fully set register
      wb(1'b1, 4'h0, 32'h0000_ffff);
      @(posedge mclk);
      rst_b <= 1'b0;
      #1 `CHK(msr, 1'b1)
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      wb(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'h3)
      `CHK(swEn, 1'b0)
      `CHK(regAct, 1'b0)
      report_and_stop;
   end
   initial begin
      #20000;
      fails++;
      report_and_stop;
   end
endmodule : tb
`default_nettype wire
